// *** acr_cmd_if.sv ***
interface acr_cmd_if;
  logic [15:0] word;
  logic [15:0] rise;
  modport src (output word, output rise);
  modport dst (input word, input rise);
endinterface : acr_cmd_if

// *** acr_cmd_reg.sv ***
module acr_cmd_reg
  import acr_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                wr_i,
  input  wire logic [CMD_W-1:0]    wdata_i,
  acr_cmd_if.src                   cif
);
  import acr_pkg::*;

  logic [CMD_W-1:0] next_word;
  logic [CMD_W-1:0] next_rise;

  always_comb begin
    next_word = cif.word;
    next_rise = '0;
    if (wr_i) begin
      next_word = wdata_i & CMD_WMASK;
      next_rise = wdata_i & CMD_WMASK & ~cif.word;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cif.word <= CMD_RESET;
      cif.rise <= '0;
    end else begin
      cif.word <= next_word;
      cif.rise <= next_rise;
    end
  end
endmodule : acr_cmd_reg

// *** acr_host_model.sv ***
module acr_host_model (
  input  wire logic        clk_i,
  output logic             wr_o,
  output logic [15:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_o    = 1'b0;
    wdata_o = 16'h0000;
  end
  // Data is inverted on release so a stale word is never mistaken for new.
  task automatic put(input logic [15:0] d);
    @(negedge clk_i);
    wr_o    = 1'b1;
    wdata_o = d;
    @(negedge clk_i);
    wr_o    = 1'b0;
    wdata_o = ~d;
  endtask : put
  task automatic fresh(input logic [15:0] base, input logic [15:0] m);
    put(base & ~m);
    put(base | m);
  endtask : fresh
endmodule : acr_host_model

// *** acr_pkg.sv ***
package acr_pkg;
  localparam int unsigned CMD_W         = 16;
  localparam int unsigned SPEED_W       = 16;
  localparam int unsigned POINT_W       = 16;
  // Bit positions inside the command word.
  localparam int unsigned BIT_HALT      = 15;
  localparam int unsigned BIT_SAFE      = 14;
  localparam int unsigned BIT_SERVO     = 12;
  localparam int unsigned BIT_FCLR      = 8;
  localparam int unsigned BIT_BRAKE     = 7;
  localparam int unsigned BIT_HOLD      = 5;
  localparam int unsigned BIT_HOME      = 4;
  localparam int unsigned BIT_MOVE      = 3;
  // Unusable bits are not stored and read back as zero.
  localparam logic [15:0] CMD_WMASK     = 16'hd1b8;
  localparam logic [15:0] CMD_RESET     = 16'h0000;
  localparam logic [15:0] SPEED_RESET   = 16'h0000;
  localparam logic [15:0] POINT_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOME,
    ST_MOVE
  } acr_state_e;
endpackage : acr_pkg

// *** acr_top.sv ***
// Functional notes
// - Bit 15 enters emergency stop; drive power stays on, fault lamp dark.
// - Bit 14 caps every motion speed at the safety speed setting.
// - Bit 12 energizes servo only if stop, failure, auto-off clear, enabled.
// - Rising bit 8 clears alarms; a persisting cause raises it again.
// - Rising bit 8 while paused discards the remaining travel.
// - Bit 7 forcibly releases the brake while it is one.
// - Bit 5 blocks motion except homing before contact reversal; a running move decelerates to stop.
// - Clearing bit 5 resumes the interrupted move to its end.
// - Bit 5 during homing holds only after contact reversal, then finishes.
// - Rising bit 4 starts homing and clears done flag; finish sets it; rehoming is allowed.
// - Rising bit 3 moves to the point in the point index register.
// - While bit 3 stays one, position complete is withheld.
// - Bit 3 start before any homing first homes, then moves.
module acr_top
  import acr_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                cmd_wr_i,
  input  wire logic [CMD_W-1:0]    cmd_wdata_i,
  output logic      [CMD_W-1:0]    cmd_rdata_o,
  input  wire logic [POINT_W-1:0]  point_index_register_i,
  input  wire logic [SPEED_W-1:0]  safety_speed_i,
  input  wire logic [SPEED_W-1:0]  req_speed_i,
  input  wire logic                estop_status_i,
  input  wire logic                major_failure_i,
  input  wire logic                enable_status_i,
  input  wire logic                auto_servo_off_i,
  input  wire logic                alarm_cause_i,
  input  wire logic                home_reversed_i,
  input  wire logic                home_finished_i,
  input  wire logic                move_finished_i,
  input  wire logic                in_band_i,
  output logic                     emergency_halt_request_o,
  output logic                     drive_power_keep_o,
  output logic                     fault_lamp_o,
  output logic                     alarm_active_o,
  output logic [SPEED_W-1:0]       speed_cap_o,
  output logic                     drive_energize_o,
  output logic                     brake_release_o,
  output logic                     motion_hold_o,
  output logic                     cancel_travel_o,
  output logic                     home_start_o,
  output logic                     move_start_o,
  output logic [POINT_W-1:0]       move_point_o,
  output logic                     homing_done_flag_o,
  output logic                     pos_complete_o
);
  import acr_pkg::*;

  acr_cmd_if cif ();

  acr_cmd_reg u_cmd (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (cmd_wr_i),
    .wdata_i   (cmd_wdata_i),
    .cif       (cif)
  );

  assign cmd_rdata_o = cif.word;

  acr_state_e          state;
  acr_state_e          next_state;
  logic                pending;
  logic                next_pending;
  logic                reversed;
  logic                next_reversed;
  logic                arrived;
  logic                next_arrived;
  logic                alarm;
  logic                next_alarm;
  logic                next_home_flag;
  logic                next_home_start;
  logic                next_move_start;
  logic                next_cancel;
  logic [POINT_W-1:0]  next_point;
  logic                paused;
  logic                next_hold;
  logic [SPEED_W-1:0]  next_cap;
  logic                next_servo;

  // A move or homing counts as paused only while one is underway.
  assign paused = cif.word[BIT_HOLD] && (state != ST_IDLE);

  always_comb begin
    next_state      = state;
    next_pending    = pending;
    next_reversed   = reversed;
    next_arrived    = arrived;
    next_home_flag  = homing_done_flag_o;
    next_home_start = 1'b0;
    next_move_start = 1'b0;
    next_cancel     = 1'b0;
    next_point      = move_point_o;
    if (cif.word[BIT_HALT]) begin
      next_state   = ST_IDLE;
      next_pending = 1'b0;
    end else if (cif.rise[BIT_FCLR] && paused) begin
      next_cancel  = 1'b1;
      next_state   = ST_IDLE;
      next_pending = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cif.rise[BIT_HOME]) begin
            next_home_start = 1'b1;
            next_home_flag  = 1'b0;
            next_reversed   = 1'b0;
            next_state      = ST_HOME;
          end else if (cif.rise[BIT_MOVE]) begin
            next_arrived = 1'b0;
            if (homing_done_flag_o) begin
              next_move_start = 1'b1;
              next_point      = point_index_register_i;
              next_state      = ST_MOVE;
            end else begin
              next_home_start = 1'b1;
              next_reversed   = 1'b0;
              next_pending    = 1'b1;
              next_point      = point_index_register_i;
              next_state      = ST_HOME;
            end
          end
        end
        ST_HOME: begin
          if (home_reversed_i) begin
            next_reversed = 1'b1;
          end
          if (home_finished_i) begin
            next_home_flag = 1'b1;
            next_state     = ST_IDLE;
            if (pending) begin
              next_move_start = 1'b1;
              next_pending    = 1'b0;
              next_state      = ST_MOVE;
            end
          end
        end
        ST_MOVE: begin
          if (move_finished_i) begin
            next_arrived = 1'b1;
            next_state   = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_alarm = alarm_cause_i | (alarm & ~cif.rise[BIT_FCLR]);
    next_hold  = cif.word[BIT_HOLD] && !(state == ST_HOME && !reversed);
    next_cap   = (cif.word[BIT_SAFE] && req_speed_i > safety_speed_i)
                 ? safety_speed_i : req_speed_i;
    next_servo = cif.word[BIT_SERVO] && !estop_status_i && !major_failure_i
                 && enable_status_i && !auto_servo_off_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state                    <= ST_IDLE;
      pending                  <= 1'b0;
      reversed                 <= 1'b0;
      arrived                  <= 1'b0;
      alarm                    <= 1'b0;
      homing_done_flag_o       <= 1'b0;
      home_start_o             <= 1'b0;
      move_start_o             <= 1'b0;
      cancel_travel_o          <= 1'b0;
      move_point_o             <= POINT_RESET;
      emergency_halt_request_o <= 1'b0;
      drive_power_keep_o       <= 1'b1;
      fault_lamp_o             <= 1'b0;
      alarm_active_o           <= 1'b0;
      speed_cap_o              <= SPEED_RESET;
      drive_energize_o         <= 1'b0;
      brake_release_o          <= 1'b0;
      motion_hold_o            <= 1'b0;
      pos_complete_o           <= 1'b0;
    end else begin
      state                    <= next_state;
      pending                  <= next_pending;
      reversed                 <= next_reversed;
      arrived                  <= next_arrived;
      alarm                    <= next_alarm;
      homing_done_flag_o       <= next_home_flag;
      home_start_o             <= next_home_start;
      move_start_o             <= next_move_start;
      cancel_travel_o          <= next_cancel;
      move_point_o             <= next_point;
      emergency_halt_request_o <= cif.word[BIT_HALT];
      drive_power_keep_o       <= 1'b1;
      fault_lamp_o             <= next_alarm & ~cif.word[BIT_HALT];
      alarm_active_o           <= next_alarm;
      speed_cap_o              <= next_cap;
      drive_energize_o         <= next_servo;
      brake_release_o          <= cif.word[BIT_BRAKE];
      motion_hold_o            <= next_hold;
      pos_complete_o           <= next_arrived & in_band_i
                                  & ~cif.word[BIT_MOVE];
    end
  end

  property p_halt;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cif.word[BIT_HALT] |=> emergency_halt_request_o && !fault_lamp_o
                             && drive_power_keep_o;
  endproperty
  a_halt: assert property (p_halt) else $error("emergency state wrong");

  property p_cap;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cif.word[BIT_SAFE] |=> speed_cap_o <= $past(safety_speed_i);
  endproperty
  a_cap: assert property (p_cap) else $error("speed over cap");

  property p_servo;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (estop_status_i || major_failure_i || !enable_status_i
       || auto_servo_off_i || !cif.word[BIT_SERVO]) |=> !drive_energize_o;
  endproperty
  a_servo: assert property (p_servo) else $error("servo without permit");

  property p_alarm;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (cif.rise[BIT_FCLR] && !alarm_cause_i) |=> !alarm_active_o;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not cleared");

  property p_cancel;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (cif.rise[BIT_FCLR] && paused && !cif.word[BIT_HALT])
        |=> cancel_travel_o && state == ST_IDLE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("travel kept");

  property p_brake;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      brake_release_o == $past(cif.word[BIT_BRAKE]);
  endproperty
  a_brake: assert property (p_brake) else $error("brake mismatch");

  property p_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (cif.word[BIT_HOLD] && state != ST_HOME) |=> motion_hold_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not applied");

  property p_home;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (state == ST_IDLE && cif.rise[BIT_HOME] && !cif.word[BIT_HALT]
       && !(cif.rise[BIT_FCLR] && paused)) |=> home_start_o
       && !homing_done_flag_o;
  endproperty
  a_home: assert property (p_home) else $error("homing not started");

  property p_move;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      move_start_o |-> homing_done_flag_o;
  endproperty
  a_move: assert property (p_move) else $error("move before homing");

  property p_pcomp;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      cif.word[BIT_MOVE] |=> !pos_complete_o;
  endproperty
  a_pcomp: assert property (p_pcomp) else $error("complete not held");
endmodule : acr_top

// *** test_actuator_command_register.sv ***
module test_actuator_command_register;
  timeunit 1ns;
  timeprecision 1ns;
  import acr_pkg::*;
  logic        clk, rst, wr, cause, band;
  logic [15:0] wd, rd, pidx, safe, req, cap, mpt;
  logic [3:0]  perm;
  logic [2:0]  eng;
  logic        halt, pkeep, lamp, fault_lamp, en, brk, hold, canc, hs, ms, hd, pc;
  int          err_count, n_checks, cyc;
  acr_host_model hm (.clk_i(clk), .wr_o(wr), .wdata_o(wd));
  acr_top i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .cmd_wr_i(wr),
    .cmd_wdata_i(wd), .cmd_rdata_o(rd), .point_index_register_i(pidx),
    .safety_speed_i(safe), .req_speed_i(req), .estop_status_i(perm[3]),
    .major_failure_i(perm[2]), .enable_status_i(perm[1]),
    .auto_servo_off_i(perm[0]), .alarm_cause_i(cause),
    .home_reversed_i(eng[0]), .home_finished_i(eng[1]),
    .move_finished_i(eng[2]), .in_band_i(band),
    .emergency_halt_request_o(halt), .drive_power_keep_o(pkeep),
    .fault_lamp_o(lamp), .alarm_active_o(fault_lamp), .speed_cap_o(cap),
    .drive_energize_o(en), .brake_release_o(brk), .motion_hold_o(hold),
    .cancel_travel_o(canc), .home_start_o(hs), .move_start_o(ms),
    .move_point_o(mpt), .homing_done_flag_o(hd), .pos_complete_o(pc));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask : cb
  // Results show in the cycle after the edge that follows the taking edge.
  task automatic st;
    @(posedge clk);
    @(negedge clk);
  endtask : st
  // A one-cycle engine pulse; its outcome stands when the task returns.
  task automatic eng_pulse(input int k);
    @(negedge clk);
    eng[k] = 1'b1;
    @(negedge clk);
    eng    = 3'b000;
  endtask : eng_pulse
  task automatic t_move_unhomed;
    hm.put(16'h0008);
    st();
    cb(hs, 1'b1);
    cb(ms, 1'b0);
    eng_pulse(1);
    cb(ms, 1'b1);
    cb(hd, 1'b1);
    chk(mpt, pidx);
    eng_pulse(2);
    cb(pc, 1'b0);
  endtask : t_move_unhomed
  task automatic t_rehome;
    hm.put(16'h0010);
    st();
    cb(hs, 1'b1);
    cb(pc, 1'b1);
    band = 1'b0;
    st();
    cb(pc, 1'b0);
    band = 1'b1;
    eng_pulse(1);
    cb(hd, 1'b1);
    hm.put(16'h0010);
    st();
    cb(hs, 1'b0);
  endtask : t_rehome
  task automatic t_pause_cancel;
    pidx = 16'h0031;
    hm.put(16'h0008);
    st();
    cb(ms, 1'b1);
    chk(mpt, 16'h0031);
    hm.put(16'h0028);
    st();
    cb(hold, 1'b1);
    hm.put(16'h0008);
    st();
    cb(hold, 1'b0);
    hm.put(16'h0028);
    st();
    cb(hold, 1'b1);
    // The cancel below only fires if the move survived the release.
    hm.put(16'h0128);
    st();
    cb(canc, 1'b1);
    hm.put(16'h0000);
  endtask : t_pause_cancel
  task automatic t_levels;
    hm.put(16'h1080);
    st();
    chk(cap, req);
    cb(en, 1'b1);
    cb(brk, 1'b1);
    hm.put(16'h5080);
    st();
    chk(cap, safe);
    req = 16'h0080;
    st();
    chk(cap, 16'h0080);
    safe = 16'h0040;
    st();
    chk(cap, 16'h0040);
    for (int i = 0; i < 4; i++) begin
      perm = 4'b0010 ^ (4'b0001 << i);
      hm.put(16'h1000);
      st();
      cb(en, 1'b0);
    end
    perm = 4'b0010;
  endtask : t_levels
  task automatic t_home_pause;
    hm.put(16'h0010);
    st();
    cb(hs, 1'b1);
    hm.put(16'h0030);
    st();
    cb(hold, 1'b0);
    eng_pulse(0);
    st();
    cb(hold, 1'b1);
    hm.put(16'h0010);
    st();
    cb(hold, 1'b0);
    eng_pulse(1);
    cb(hd, 1'b1);
    hm.fresh(16'h0000, 16'h0010);
    st();
    cb(hs, 1'b1);
    eng_pulse(1);
  endtask : t_home_pause
  task automatic t_alarm_emg;
    cause = 1'b1;
    hm.fresh(16'h0000, 16'h0100);
    st();
    cb(fault_lamp, 1'b1);
    cause = 1'b0;
    hm.fresh(16'h0000, 16'h0100);
    st();
    cb(fault_lamp, 1'b0);
    cause = 1'b1;
    hm.put(16'hffff);
    cause = 1'b0;
    st();
    chk(rd, CMD_WMASK);
    cb(halt, 1'b1);
    cb(pkeep, 1'b1);
    cb(lamp, 1'b0);
    cb(fault_lamp, 1'b1);
  endtask : t_alarm_emg
  initial begin
    rst       = 1'b1;
    cause     = 1'b0;
    band      = 1'b1;
    eng       = 3'b000;
    perm      = 4'b0010;
    pidx      = 16'h002a;
    safe      = 16'h0100;
    req       = 16'h0200;
    err_count = 0;
    n_checks  = 0;
    cyc       = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(rd, CMD_RESET);
    cb(pkeep, 1'b1);
    t_move_unhomed();
    t_rehome();
    t_pause_cancel();
    t_levels();
    t_home_pause();
    t_alarm_emg();
    complete_run();
  end
endmodule : test_actuator_command_register
